// ===== inc/vcpt_defs.vh
// constants for the voltage channel phase trim stage
`ifndef VCPT_DEFS_VH
`define VCPT_DEFS_VH

// sample width of both channels
`define VCPT_SW 16
// trim code width, signed two's complement
`define VCPT_CW 8
// code at which no shift applies
`define VCPT_ZERO_CODE 8'sh0d
// master clock periods per trim step
`define VCPT_STEP_CLKS 4'h8
// width of the step divider
`define VCPT_DIV_W 4
// highest usable code, sets the depth of the voltage delay line
`define VCPT_MAX_CODE 8'sh3f
// number of voltage taps (codes 0 .. max)
`define VCPT_VDEPTH 64
// tap index width
`define VCPT_IW 6
// current line depth: zero code plus the one step the voltage tap read adds
`define VCPT_IDEPTH 14
// reset value of sample registers
`define VCPT_SAMPLE_RST 16'h0000
`define VCPT_DIV_RST 4'h0
`define VCPT_TAP_RST 6'h0d

`endif

// ===== rtl/vcpt_phase_trim.v
// voltage channel phase trim: steps voltage samples against current
//
// Notes on behaviour
// - shift voltage channel only, current stays aligned
// - shift equals (code minus 13) times eight clocks
// - above 13 delays, below advances, 13 none
// - trim code is signed two's complement
// - range covers 0.72 lead, 1.84 lag; the code spans 13 steps lead (code 0) to 50 steps lag (code 63)
// - correction opposes error, scaled by line period
//
// An advance cannot be made in causal hardware, so both channels are
// delayed by the zero-point (13 steps); the voltage tap then moves
// earlier or later than the current tap. The net relative shift between
// the two channels is exactly (code - 13) steps of eight clocks.
// Codes outside 0 .. max are clamped and flagged.
// the current line is one stage deeper than the zero point because the
// voltage tap is read one step after capture; this keeps code 13 aligned.
// a new code takes effect at the next step, so the voltage output may
// jump by several samples when the tap moves; downstream must tolerate it.
`include "vcpt_defs.vh"

module vcpt_phase_trim (
  clk,
  resetn,
  phase_trim_code,
  trim_load,
  volt_in,
  curr_in,
  volt_out,
  curr_out,
  sample_tick,
  trim_clamped,
  active_tap
);
  input wire clk;
  input wire resetn;
  input wire [`VCPT_CW-1:0] phase_trim_code;
  input wire trim_load;
  input wire [`VCPT_SW-1:0] volt_in;
  input wire [`VCPT_SW-1:0] curr_in;
  output reg [`VCPT_SW-1:0] volt_out;
  output reg [`VCPT_SW-1:0] curr_out;
  output reg sample_tick;
  output reg trim_clamped;
  output reg [`VCPT_IW-1:0] active_tap;

  // map a signed code onto a tap index, clamping to the line
  function [`VCPT_IW:0] code_to_tap;
    input [`VCPT_CW-1:0] code;
    reg signed [`VCPT_CW-1:0] sc;
    begin
      sc = code;
      if (sc < 0) begin
        code_to_tap = {1'b1, {`VCPT_IW{1'b0}}};
      end else if (sc > `VCPT_MAX_CODE) begin
        code_to_tap = {1'b1, {`VCPT_IW{1'b1}}};
      end else begin
        code_to_tap = {1'b0, sc[`VCPT_IW-1:0]};
      end
    end
  endfunction

  // wrap-around count of master clocks within one step
  function [`VCPT_DIV_W-1:0] div_next;
    input [`VCPT_DIV_W-1:0] cnt;
    begin
      if (cnt == `VCPT_STEP_CLKS - 4'h1) begin
        div_next = `VCPT_DIV_RST;
      end else begin
        div_next = cnt + 4'h1;
      end
    end
  endfunction

  reg [`VCPT_DIV_W-1:0] div_q;
  reg [`VCPT_DIV_W-1:0] div_d;
  reg tick_q;
  reg tick_d;
  reg [`VCPT_IW-1:0] tap_q;
  reg [`VCPT_IW-1:0] tap_d;
  reg clamp_q;
  reg clamp_d;
  reg [`VCPT_SW-1:0] vline_q [0:`VCPT_VDEPTH-1];
  reg [`VCPT_SW-1:0] iline_q [0:`VCPT_IDEPTH-1];
  reg [`VCPT_SW-1:0] vtap_d;
  reg [`VCPT_SW-1:0] itap_d;
  wire [`VCPT_IW:0] map_w;
  integer k;

  assign map_w = code_to_tap(phase_trim_code);

  // step divider next state
  always @* begin
    div_d = div_next(div_q);
    tick_d = (div_q == `VCPT_STEP_CLKS - 4'h1);
  end

  // one step every eight master clocks
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_q <= `VCPT_DIV_RST;
    end else begin
      div_q <= div_d;
    end
  end

  // step pulse, one clock wide
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tick_q <= 1'b0;
    end else begin
      tick_q <= tick_d;
    end
  end

  // trim code is held until the next load
  always @* begin
    tap_d = tap_q;
    clamp_d = clamp_q;
    if (trim_load) begin
      tap_d = map_w[`VCPT_IW-1:0];
      clamp_d = map_w[`VCPT_IW];
    end
  end

  // tap in use
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tap_q <= `VCPT_TAP_RST;
    end else begin
      tap_q <= tap_d;
    end
  end

  // out of range flag for the last load
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      clamp_q <= 1'b0;
    end else begin
      clamp_q <= clamp_d;
    end
  end

  // voltage delay line, one stage per step
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (k = 0; k < `VCPT_VDEPTH; k = k + 1) begin
        vline_q[k] <= `VCPT_SAMPLE_RST;
      end
    end else if (tick_q) begin
      vline_q[0] <= volt_in;
      for (k = 1; k < `VCPT_VDEPTH; k = k + 1) begin
        vline_q[k] <= vline_q[k-1];
      end
    end
  end

  // current line fixed at one stage past the zero-point depth
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (k = 0; k < `VCPT_IDEPTH; k = k + 1) begin
        iline_q[k] <= `VCPT_SAMPLE_RST;
      end
    end else if (tick_q) begin
      iline_q[0] <= curr_in;
      for (k = 1; k < `VCPT_IDEPTH; k = k + 1) begin
        iline_q[k] <= iline_q[k-1];
      end
    end
  end

  // tap above zero-point is later, below is earlier
  always @* begin
    vtap_d = vline_q[tap_q];
    itap_d = iline_q[`VCPT_IDEPTH-1];
  end

  // outputs, each straight from its own flip-flop
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      volt_out <= `VCPT_SAMPLE_RST;
    end else if (tick_q) begin
      volt_out <= vtap_d;
    end
  end

  // current path, fixed depth
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      curr_out <= `VCPT_SAMPLE_RST;
    end else if (tick_q) begin
      curr_out <= itap_d;
    end
  end

  // marks a fresh sample pair
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sample_tick <= 1'b0;
    end else begin
      sample_tick <= tick_q;
    end
  end

  // status mirrors of the held trim
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      trim_clamped <= 1'b0;
    end else begin
      trim_clamped <= clamp_q;
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      active_tap <= `VCPT_TAP_RST;
    end else begin
      active_tap <= tap_q;
    end
  end

endmodule

// ===== tb/vcpt_adc_model.sv
// adc source: ramp samples renewed every eight clocks
module vcpt_adc_model(input wire logic clk,
  output logic [15:0] volt, output logic [15:0] curr);
  timeunit 1ns;
  timeprecision 1ns;
  logic [18:0] k = 19'h0;
  always @(negedge clk) k <= k + 19'h1;
  assign curr = k[18:3];
  assign volt = k[18:3] + 16'h4000;
endmodule

// ===== tb/vcpt_phase_trim_bench.sv
// bench for the phase trim stage
module vcpt_phase_trim_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, resetn = 0, trim_load = 0, sample_tick, trim_clamped;
  logic [7:0] phase_trim_code = 8'h0d;
  logic [15:0] volt_in, curr_in, volt_out, curr_out;
  logic [5:0] active_tap;
  logic [31:0] lfsr = 32'h546b;
  int error_cnt = 0, tests_run = 0, cyc = 0, tap, c;
  int codes[$] = '{13, 0, 63, -3, 100, 12, 14};
  initial forever #5 clk = ~clk;
  vcpt_adc_model adc(.clk(clk), .volt(volt_in), .curr(curr_in));
  vcpt_phase_trim uut(.clk(clk), .resetn(resetn), .trim_load(trim_load),
    .phase_trim_code(phase_trim_code), .volt_in(volt_in),
    .curr_in(curr_in), .volt_out(volt_out), .curr_out(curr_out),
    .sample_tick(sample_tick), .trim_clamped(trim_clamped),
    .active_tap(active_tap));
  function automatic logic [31:0] nxt(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task chk(string n, logic [15:0] e, logic [15:0] s);
    tests_run++;
    if (s !== e) begin
      $display("MISMATCH %s exp %h got %h", n, e, s);
      error_cnt++;
    end
  endtask
  task tally_and_finish;
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      error_cnt++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (4) @(negedge clk);
    resetn = 1;
    repeat (600) @(negedge clk);
    for (int i = 0; i < 14; i++) begin
      lfsr = nxt(lfsr);
      c = i < codes.size() ? codes[i] : int'(lfsr[5:0]);
      phase_trim_code = c[7:0];
      trim_load = 1;
      @(negedge clk) trim_load = 0;
      tap = c < 0 ? 0 : (c > 63 ? 63 : c);
      repeat (20) @(negedge clk);
      @(posedge sample_tick);
      @(negedge clk);
      chk("tap", tap, active_tap);
      chk("clamp", c < 0 || c > 63, trim_clamped);
      chk("shift", curr_out - (tap - 13) + 16'h4000, volt_out);
    end
    tally_and_finish;
  end
endmodule

// ===== tb/vcpt_properties.sv
// port assertions for the phase trim stage
module vcpt_props(input wire logic clk, resetn, trim_load, sample_tick,
  input wire logic trim_clamped, input wire logic [7:0] phase_trim_code,
  input wire logic [15:0] curr_out, input wire logic [5:0] active_tap);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  tick_period_a: assert property (
    sample_tick |-> ##8 sample_tick) else $error("tick period");
  tick_pulse_a: assert property (
    sample_tick |=> !sample_tick) else $error("tick width");
  tap_load_a: assert property (
    trim_load && phase_trim_code < 8'h40 |-> ##2
    active_tap == $past(phase_trim_code[5:0], 2) && !trim_clamped)
    else $error("tap load");
  neg_clamp_a: assert property (
    trim_load && phase_trim_code[7] |-> ##2
    active_tap == 6'h00 && trim_clamped) else $error("low clamp");
  high_clamp_a: assert property (
    trim_load && phase_trim_code[7:6] == 2'b01 |-> ##2
    active_tap == 6'h3f && trim_clamped) else $error("high clamp");
  tap_hold_a: assert property (
    !trim_load ##1 !trim_load |=> $stable(active_tap)) else $error("hold");
  curr_step_a: assert property (
    $changed(curr_out) |-> ##[0:1] sample_tick) else $error("curr step");
endmodule
bind vcpt_phase_trim vcpt_props u_p(.clk(clk), .resetn(resetn),
  .trim_load(trim_load), .sample_tick(sample_tick),
  .trim_clamped(trim_clamped), .phase_trim_code(phase_trim_code),
  .curr_out(curr_out), .active_tap(active_tap));
